// ==== hdl/lsd_pkg.sv ====
// Constants, types and rule overview for the supply/temperature diag block
// Overview of operation
// - Gate-supply code sets regulator target voltage
// - High codes may trip bootstrap undervoltage
// - Die temperature readable as signed code
// - Periodic bootstrap recharge when not switching
// - Charge compensation needs driver on, dim low
// - Status register one bit layout
// - Serial error flag shows last command result
// - Fault flag set when overload protection trips
// - Current-reached flag per channel, last cycle
// - Input flag follows undervoltage comparator
// - Input flag high enables switching and current
// - Input flag low stops regulator, clears good
// - No fault while input low; measure gating
// - Fault after 12 ms startup, 1 ms run
// - Overtemp stops driver, fault if good
// - Write to status one clears serial error
// - Reached flags update on fall or copy
`default_nettype none
package lsd_pkg;
	localparam logic [7:0] ADDR_GATE_SUPPLY_TARGET = 8'h01;
	localparam logic [7:0] ADDR_DIE_TEMPERATURE    = 8'h26;
	localparam logic [7:0] ADDR_STATUS_FLAGS_ONE   = 8'h37;
	localparam logic [7:0] GATE_SUPPLY_RESET       = 8'h5d;
	localparam logic [7:0] CODE_MIN_ALLOWED        = 8'h5d;
	localparam logic [7:0] CODE_MAX_ALLOWED        = 8'ha6;
	localparam int STATUS_INPUT_BIT   = 7;
	localparam int STATUS_SERIAL_BIT  = 6;
	localparam int STATUS_OVERT_BIT   = 5;
	localparam int STATUS_FAULT_BIT   = 4;
	localparam int STATUS_GOOD_BIT    = 3;
	localparam int CLK_HZ             = 50000000;
	localparam int STARTUP_WAIT_US    = 12000;
	localparam int RUN_WAIT_US        = 1000;
	localparam int STARTUP_WAIT_CYC   = STARTUP_WAIT_US * (CLK_HZ / 1000000);
	localparam int RUN_WAIT_CYC       = RUN_WAIT_US * (CLK_HZ / 1000000);
	localparam int RECHARGE_PERIOD_CYC = 5000;
	localparam int STATIC_MEAS_CYC     = 500;
	localparam int CNT_W               = 20;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lsd_req_t;

	typedef enum logic [1:0] {
		SUP_OFF   = 2'b00,
		SUP_START = 2'b01,
		SUP_RUN   = 2'b10,
		SUP_FAULT = 2'b11
	} lsd_sup_t;
endpackage : lsd_pkg
`default_nettype wire

// ==== hdl/lsd_chan.sv ====
// One channel: reached flag, bootstrap recharge and charge compensation
`default_nettype none
module lsd_chan #(
	parameter int RECHARGE_CYC = lsd_pkg::RECHARGE_PERIOD_CYC,
	parameter int STATIC_CYC   = lsd_pkg::STATIC_MEAS_CYC
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic dim_in,
	input  wire logic reached_raw,
	input  wire logic copy_req,
	input  wire logic clear_evt,
	input  wire logic driver_en,
	input  wire logic bootstrap_undervoltage,
	input  wire logic headroom_low,
	input  wire logic switching,
	output logic      reached_flag,
	output logic      recharge_pulse,
	output logic      comp_en
);
	logic                          dim_d_reg, dim_d_next;
	logic                          flag_reg, flag_next;
	logic [lsd_pkg::CNT_W-1:0]     low_cnt_reg, low_cnt_next;
	logic [lsd_pkg::CNT_W-1:0]     per_cnt_reg, per_cnt_next;
	logic                          need_recharge;
	logic                          pulse_next, pulse_reg;

	always_comb begin
		dim_d_next = dim_in;
		flag_next  = flag_reg;
		if (clear_evt) begin
			flag_next = 1'b0;
		end else if ((dim_d_reg && !dim_in) || copy_req) begin
			flag_next = reached_raw;
		end
		low_cnt_next = dim_in ? '0 : low_cnt_reg;
		if (!dim_in && low_cnt_reg < lsd_pkg::CNT_W'(STATIC_CYC)) begin
			low_cnt_next = low_cnt_reg + 1'b1;
		end
		need_recharge = !switching && driver_en &&
			((!dim_in && low_cnt_reg >= lsd_pkg::CNT_W'(STATIC_CYC)) ||
			 (dim_in && !reached_raw));
		per_cnt_next = '0;
		pulse_next   = 1'b0;
		if (need_recharge) begin
			if (per_cnt_reg >= lsd_pkg::CNT_W'(RECHARGE_CYC - 1)) begin
				pulse_next = 1'b1;
			end else begin
				per_cnt_next = per_cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dim_d_reg   <= 1'b0;
			flag_reg    <= 1'b0;
			low_cnt_reg <= '0;
			per_cnt_reg <= '0;
			pulse_reg   <= 1'b0;
		end else begin
			dim_d_reg   <= dim_d_next;
			flag_reg    <= flag_next;
			low_cnt_reg <= low_cnt_next;
			per_cnt_reg <= per_cnt_next;
			pulse_reg   <= pulse_next;
		end
	end

	assign reached_flag   = flag_reg;
	assign recharge_pulse = pulse_reg;
	assign comp_en = driver_en && !dim_in && !bootstrap_undervoltage &&
		!headroom_low;

	property p_clear;
		@(posedge clk) disable iff (srst) clear_evt |=> !flag_reg;
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
	property p_comp;
		@(posedge clk) disable iff (srst) comp_en |-> driver_en && !dim_in;
	endproperty
	a_comp: assert property (p_comp) else $error("bad comp enable");
endmodule : lsd_chan
`default_nettype wire

// ==== hdl/lsd_top.sv ====
// Supply, temperature and status register bank with fault sequencing
`default_nettype none
module lsd_top #(
	parameter int STARTUP_CYC = lsd_pkg::STARTUP_WAIT_CYC,
	parameter int RUN_CYC     = lsd_pkg::RUN_WAIT_CYC
) (
	input  wire logic             REF_CLK,
	input  wire logic             SRST,
	input  wire lsd_pkg::lsd_req_t REQ,
	input  wire logic             CMD_ERR,
	output logic [7:0]            RDATA,
	output logic                  RVALID,
	input  wire logic             INPUT_ABOVE_UV,
	input  wire logic             OVERTEMP_IN,
	input  wire logic             SUPPLY_AT_TARGET,
	input  wire logic [7:0]       TEMP_CODE,
	input  wire logic [2:0]       DIM_IN,
	input  wire logic [2:0]       REACHED_RAW,
	input  wire logic [2:0]       COPY_REQ,
	input  wire logic [2:0]       HEADROOM_LOW,
	input  wire logic [2:0]       SWITCHING,
	input  wire logic             BOOTSTRAP_UNDERVOLTAGE,
	input  wire logic             CLEAR_ERRORS,
	output logic [7:0]            GATE_SUPPLY_CODE,
	output logic                  REGULATOR_EN,
	output logic                  DRIVER_EN,
	output logic [2:0]            CHANNEL_EN,
	output logic                  MEASURE_UPDATE,
	output logic [2:0]            RECHARGE_PULSE,
	output logic [2:0]            COMP_EN
);
	// ==========================================================
	// Input synchronisers
	logic [7:0] s1_reg, s2_reg;
	logic [2:0] d1_reg, d2_reg;
	logic in_ok, ovt, at_tgt;
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			s1_reg <= 8'h00;
			s2_reg <= 8'h00;
			d1_reg <= 3'h0;
			d2_reg <= 3'h0;
		end else begin
			s1_reg <= {5'h00, INPUT_ABOVE_UV, OVERTEMP_IN, SUPPLY_AT_TARGET};
			s2_reg <= s1_reg;
			d1_reg <= DIM_IN;
			d2_reg <= d1_reg;
		end
	end
	assign in_ok  = s2_reg[2];
	assign ovt    = s2_reg[1];
	assign at_tgt = s2_reg[0];

	// ==========================================================
	// Registers and supply sequencing
	logic [7:0]        code_reg, code_next;
	logic              serr_reg, serr_next;
	logic              fault_reg, fault_next;
	logic              good_reg, good_next;
	logic [7:0]        rdata_reg, rdata_next;
	logic              rvalid_reg, rvalid_next;
	logic [lsd_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	lsd_pkg::lsd_sup_t st_reg, st_next;
	logic [2:0]        reached;
	logic [7:0]        status;
	logic              active;

	assign status = {in_ok, serr_reg, ovt, fault_reg, good_reg, reached};

	always_comb begin
		code_next   = code_reg;
		serr_next   = serr_reg;
		rdata_next  = rdata_reg;
		rvalid_next = 1'b0;
		if (REQ.wr) begin
			serr_next = CMD_ERR;
			if (!CMD_ERR && REQ.addr == lsd_pkg::ADDR_GATE_SUPPLY_TARGET) begin
				code_next = REQ.wdata;
			end else if (!CMD_ERR &&
				REQ.addr == lsd_pkg::ADDR_STATUS_FLAGS_ONE) begin
				serr_next = 1'b0;
			end else if (REQ.addr != lsd_pkg::ADDR_GATE_SUPPLY_TARGET) begin
				serr_next = 1'b1;
			end
		end else if (REQ.rd) begin
			rvalid_next = 1'b1;
			serr_next   = CMD_ERR;
			unique case (REQ.addr)
				lsd_pkg::ADDR_GATE_SUPPLY_TARGET: rdata_next = code_reg;
				lsd_pkg::ADDR_DIE_TEMPERATURE:    rdata_next = TEMP_CODE;
				lsd_pkg::ADDR_STATUS_FLAGS_ONE:   rdata_next = status;
				default: begin
					rdata_next = 8'h00;
					serr_next  = 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		st_next    = st_reg;
		cnt_next   = cnt_reg;
		fault_next = fault_reg;
		good_next  = good_reg;
		if (CLEAR_ERRORS && !ovt) begin
			fault_next = 1'b0;
		end
		unique case (st_reg)
			lsd_pkg::SUP_OFF: begin
				cnt_next = '0;
				if (in_ok && !ovt && !fault_reg) begin
					st_next = lsd_pkg::SUP_START;
				end
			end
			lsd_pkg::SUP_START, lsd_pkg::SUP_RUN: begin
				cnt_next = at_tgt ? '0 : cnt_reg + 1'b1;
				if (at_tgt) begin
					good_next = 1'b1;
					st_next   = lsd_pkg::SUP_RUN;
				end
				if (!at_tgt && ((st_reg == lsd_pkg::SUP_START &&
					cnt_reg >= lsd_pkg::CNT_W'(STARTUP_CYC - 1)) ||
					(st_reg == lsd_pkg::SUP_RUN &&
					cnt_reg >= lsd_pkg::CNT_W'(RUN_CYC - 1)))) begin
					fault_next = 1'b1;
					good_next  = 1'b0;
					st_next    = lsd_pkg::SUP_FAULT;
				end
				if (ovt) begin
					fault_next = fault_reg || good_reg;
					good_next  = 1'b0;
					st_next    = lsd_pkg::SUP_FAULT;
				end
			end
			lsd_pkg::SUP_FAULT: begin
				good_next = 1'b0;
				cnt_next  = '0;
				if (!fault_next && !ovt) begin
					st_next = lsd_pkg::SUP_OFF;
				end
			end
		endcase
		if (!in_ok) begin
			good_next = 1'b0;
			fault_next = fault_reg && !(CLEAR_ERRORS && !ovt);
			st_next   = (st_reg == lsd_pkg::SUP_FAULT) ?
				lsd_pkg::SUP_FAULT : lsd_pkg::SUP_OFF;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			code_reg   <= lsd_pkg::GATE_SUPPLY_RESET;
			serr_reg   <= 1'b0;
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
			st_reg     <= lsd_pkg::SUP_OFF;
			cnt_reg    <= '0;
			fault_reg  <= 1'b0;
			good_reg   <= 1'b0;
		end else begin
			code_reg   <= code_next;
			serr_reg   <= serr_next;
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
			st_reg     <= st_next;
			cnt_reg    <= cnt_next;
			fault_reg  <= fault_next;
			good_reg   <= good_next;
		end
	end

	// ==========================================================
	// Outputs and channels
	assign active = in_ok && (st_reg == lsd_pkg::SUP_START ||
		st_reg == lsd_pkg::SUP_RUN);
	assign RDATA            = rdata_reg;
	assign RVALID           = rvalid_reg;
	assign GATE_SUPPLY_CODE = code_reg;
	assign REGULATOR_EN     = active;
	assign DRIVER_EN        = active && good_reg;
	assign CHANNEL_EN       = {3{active && good_reg}} & d2_reg;
	assign MEASURE_UPDATE   = in_ok && good_reg;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_ch
			lsd_chan u_chan (
				.clk           (REF_CLK),
				.srst          (SRST),
				.dim_in        (d2_reg[g]),
				.reached_raw   (REACHED_RAW[g]),
				.copy_req      (COPY_REQ[g]),
				.clear_evt     (!in_ok || HEADROOM_LOW[g]),
				.driver_en     (DRIVER_EN),
				.bootstrap_undervoltage(BOOTSTRAP_UNDERVOLTAGE),
				.headroom_low  (HEADROOM_LOW[g]),
				.switching     (SWITCHING[g]),
				.reached_flag  (reached[g]),
				.recharge_pulse(RECHARGE_PULSE[g]),
				.comp_en       (COMP_EN[g])
			);
		end
	endgenerate

	// ==========================================================
	// Checks
	property p_nofault_low;
		@(posedge REF_CLK) disable iff (SRST)
			!in_ok && !fault_reg |=> !fault_reg;
	endproperty
	a_nofault_low: assert property (p_nofault_low) else $error("fault set");
	property p_good_low;
		@(posedge REF_CLK) disable iff (SRST) !in_ok |=> !good_reg;
	endproperty
	a_good_low: assert property (p_good_low) else $error("good stays");
	property p_readback;
		@(posedge REF_CLK) disable iff (SRST)
			REQ.wr && !CMD_ERR && REQ.addr == 8'h01 ##1
			REQ.rd && !REQ.wr && REQ.addr == 8'h01
			|=> RDATA == $past(REQ.wdata, 2) && RVALID;
	endproperty
	a_readback: assert property (p_readback) else $error("readback");
	property p_serr_clr;
		@(posedge REF_CLK) disable iff (SRST)
			REQ.wr && !CMD_ERR && REQ.addr == 8'h37 |=> !serr_reg;
	endproperty
	a_serr_clr: assert property (p_serr_clr) else $error("serr");
	property p_ovt;
		@(posedge REF_CLK) disable iff (SRST)
			ovt && good_reg && in_ok |=> fault_reg && !good_reg;
	endproperty
	a_ovt: assert property (p_ovt) else $error("overtemp");
	property p_drv;
		@(posedge REF_CLK) disable iff (SRST) DRIVER_EN |-> in_ok && !fault_reg;
	endproperty
	a_drv: assert property (p_drv) else $error("driver on");
	property p_ro;
		@(posedge REF_CLK) disable iff (SRST)
			REQ.wr && REQ.addr == 8'h26 |=> serr_reg;
	endproperty
	a_ro: assert property (p_ro) else $error("ro write");
	property p_meas;
		@(posedge REF_CLK) disable iff (SRST)
			MEASURE_UPDATE |-> status[7] && status[3];
	endproperty
	a_meas: assert property (p_meas) else $error("measure");
endmodule : lsd_top
`default_nettype wire

// ==== dv/lsd_host.sv ====
// Host controller model that issues register requests
`default_nettype none
module lsd_host (
	input  wire logic         clk,
	input  wire logic [7:0]   rdata,
	input  wire logic         rvalid,
	output lsd_pkg::lsd_req_t req,
	output logic              cmd_err
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		req = '0;
		cmd_err = 1'b0;
	end

	// ==========================================
	// One request, held for the taking edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic e, output logic [7:0] q);
		@(posedge clk);
		#1;
		req = '{wr: w, rd: ~w, addr: a, wdata: d};
		cmd_err = e;
		@(posedge clk);
		#1;
		// Released lines show inverted last value
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		cmd_err = 1'b0;
		q = (!w && rvalid === 1'b1) ? rdata : 8'hxx;
	endtask

	// ==========================================
	// only allowed codes from callers
	task automatic set_code(input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		#1;
		req = '{wr: 1'b1, rd: 1'b0,
			addr: lsd_pkg::ADDR_GATE_SUPPLY_TARGET, wdata: d};
		cmd_err = 1'b0;
		@(posedge clk);
		#1;
		// Read follows the write on the very next edge
		req = '{wr: 1'b0, rd: 1'b1,
			addr: lsd_pkg::ADDR_GATE_SUPPLY_TARGET, wdata: d};
		@(posedge clk);
		#1;
		req = '{wr: 1'b0, rd: 1'b0,
			addr: ~lsd_pkg::ADDR_GATE_SUPPLY_TARGET, wdata: ~d};
		q = (rvalid === 1'b1) ? rdata : 8'hxx;
	endtask
endmodule // lsd_host
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the supply, temperature and status bank
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] exp;
	} lsd_row_t;
	logic              clk, srst, uv_ok, ovt, at_tgt, boot_uv, clr;
	logic [7:0]        temp, rdata, code, q;
	logic [2:0]        dim, raw, copy, head, sw, ch_en, rech, comp;
	logic              rvalid, reg_en, drv_en, meas, cerr;
	lsd_pkg::lsd_req_t req;
	int                fails, compares, n;
	lsd_row_t          rows [3] = '{'{8'h5d, 8'h5d}, '{8'h80, 8'h80},
		'{8'ha6, 8'ha6}};

	lsd_host host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req),
		.cmd_err(cerr));
	lsd_top #(.STARTUP_CYC(20), .RUN_CYC(5)) DUT (.REF_CLK(clk),
		.SRST(srst), .REQ(req), .CMD_ERR(cerr), .RDATA(rdata),
		.RVALID(rvalid), .INPUT_ABOVE_UV(uv_ok), .OVERTEMP_IN(ovt),
		.SUPPLY_AT_TARGET(at_tgt), .TEMP_CODE(temp), .DIM_IN(dim),
		.REACHED_RAW(raw), .COPY_REQ(copy), .HEADROOM_LOW(head),
		.SWITCHING(sw), .BOOTSTRAP_UNDERVOLTAGE(boot_uv),
		.CLEAR_ERRORS(clr),
		.GATE_SUPPLY_CODE(code), .REGULATOR_EN(reg_en),
		.DRIVER_EN(drv_en), .CHANNEL_EN(ch_en), .MEASURE_UPDATE(meas),
		.RECHARGE_PULSE(rech), .COMP_EN(comp));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, a, 8'h00, 1'b0, q);
	endtask

	task automatic wr(input logic [7:0] a, input logic e);
		logic [7:0] dummy;
		host.xfer(1'b1, a, 8'h00, e, dummy);
	endtask

	task automatic do_reset();
		srst = 1'b1;
		cyc(5);
		srst = 1'b0;
	endtask

	task automatic clear_err();
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
	endtask

	task automatic wrap_up();
		if (fails == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		#(20 * 40000);
		fails++;
		wrap_up();
	end

	initial begin
		{srst, uv_ok, ovt, at_tgt, boot_uv, clr} = '0;
		{temp, dim, raw, copy, head, sw} = '0;
		do_reset();
		// ==========================================
		// Code table write and read back
		foreach (rows[i]) begin
			host.set_code(rows[i].code, q);
			chk(q, rows[i].exp);
			chk(code, rows[i].exp);
		end
		// ==========================================
		// Reset mid-run, then startup fault
		do_reset();
		rd(lsd_pkg::ADDR_GATE_SUPPLY_TARGET);
		chk(q, lsd_pkg::GATE_SUPPLY_RESET);
		uv_ok = 1'b1;
		cyc(6);
		rd(lsd_pkg::ADDR_STATUS_FLAGS_ONE);
		chk(q, 8'h80);
		cyc(30);
		rd(lsd_pkg::ADDR_STATUS_FLAGS_ONE);
		chk(q & 8'hf8, 8'h90);
		chk({7'h00, reg_en}, 8'h00);
		// ==========================================
		// Recovery, enables and compensation
		clear_err();
		at_tgt = 1'b1;
		cyc(10);
		rd(lsd_pkg::ADDR_STATUS_FLAGS_ONE);
		chk(q, 8'h88);
		chk({5'h00, reg_en, drv_en, meas}, 8'h07);
		chk({5'h00, comp}, 8'h07);
		boot_uv = 1'b1;
		cyc(2);
		chk({5'h00, comp}, 8'h00);
		boot_uv = 1'b0;
		n = 0;
		while (rech[0] !== 1'b1 && n < 6000) begin
			cyc(1);
			n++;
		end
		chk({7'h00, rech[0]}, 8'h01);
		// ==========================================
		// Temperature and serial error
		temp = 8'hd8;
		rd(lsd_pkg::ADDR_DIE_TEMPERATURE);
		chk(q, 8'hd8);
		wr(lsd_pkg::ADDR_DIE_TEMPERATURE, 1'b0);
		rd(lsd_pkg::ADDR_STATUS_FLAGS_ONE);
		chk(q & 8'h40, 8'h40);
		rd(lsd_pkg::ADDR_DIE_TEMPERATURE);
		chk(q, 8'hd8);
		wr(lsd_pkg::ADDR_STATUS_FLAGS_ONE, 1'b0);
		rd(lsd_pkg::ADDR_STATUS_FLAGS_ONE);
		chk(q & 8'h40, 8'h00);
		// ==========================================
		// Reached flags: fall, copy, headroom
		raw = 3'h5;
		dim = 3'h7;
		cyc(4);
		chk({5'h00, ch_en}, 8'h07);
		dim = 3'h0;
		cyc(5);
		rd(lsd_pkg::ADDR_STATUS_FLAGS_ONE);
		chk(q & 8'h07, 8'h05);
		raw = 3'h2;
		copy = 3'h2;
		cyc(1);
		copy = 3'h0;
		head = 3'h1;
		cyc(2);
		head = 3'h0;
		rd(lsd_pkg::ADDR_STATUS_FLAGS_ONE);
		chk(q & 8'h07, 8'h06);
		// ==========================================
		// Run fault, overtemp, input loss
		at_tgt = 1'b0;
		cyc(15);
		rd(lsd_pkg::ADDR_STATUS_FLAGS_ONE);
		chk(q & 8'hf8, 8'h90);
		clear_err();
		at_tgt = 1'b1;
		cyc(10);
		ovt = 1'b1;
		cyc(6);
		rd(lsd_pkg::ADDR_STATUS_FLAGS_ONE);
		chk(q & 8'hf8, 8'hb0);
		chk({6'h00, reg_en, drv_en}, 8'h00);
		temp = 8'hc0;
		rd(lsd_pkg::ADDR_DIE_TEMPERATURE);
		chk(q, 8'hc0);
		uv_ok = 1'b0;
		cyc(6);
		rd(lsd_pkg::ADDR_STATUS_FLAGS_ONE);
		chk(q, 8'h30);
		ovt = 1'b0;
		// Let the synchronised overtemp flag drop first
		cyc(3);
		clear_err();
		at_tgt = 1'b0;
		cyc(40);
		rd(lsd_pkg::ADDR_STATUS_FLAGS_ONE);
		chk(q, 8'h00);
		chk({7'h00, meas}, 8'h00);
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
